// [hdl/cfg_chain_loader.sv]
// single-image chain configuration loader, master or slave by strap
// ----------------------------------------------------------------
// Summary of operation
// [R1] The master strap selects the serial flash scheme and every slave is strapped to value 01.
// [R2] All devices take the same image at once so the chain configures in one cycle.
// [R3] The system ties each chain enable input low; the chain enable output is free for user use. The code drives it low one cycle behind ST_DONE.
// [R4] Data and configuration clock reach every device in parallel, so slaves see the flash stream.
// [R5] The master makes the configuration clock itself and moves one bit per clock cycle.
// [R6] The configuration clock never runs slower than 20 MHz, a period of at most 50 ns.
// [R7] The typical configuration clock period is about 38.46 ns for time estimates.
// [R8] Every device accepts a compressed or an uncompressed image.
// [R9] While the chain enable input is high the device keeps off the flash interface.
// [R10] While the restart input is low the device stays in reset.
// [R11] After programming the programmer releases chain enable and restart to low and high.
// [R12] A slave latches configuration data on the rising configuration clock edge.
// [R13] Each device holds the shared done line low until all its data has arrived.
// [R14] On error the status line is driven low and auto restart follows within 40 us; after 2000 or more ST_WAIT cycles restart waits for a timer wrap.
// ----------------------------------------------------------------
`timescale 1ns/1ns
module cfg_chain_loader #(
	parameter int RAW_BITS = cfg_chain_pkg::RAW_IMAGE_BITS,
	parameter int PACKED_BITS = cfg_chain_pkg::PACKED_IMAGE_BITS,
	parameter int DONE_TIMEOUT = cfg_chain_pkg::DONE_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// straps and options
	input wire logic [1:0] scheme_select,
	input wire logic image_compressed,
	input wire logic auto_restart,
	// chain and restart pins
	input wire logic chain_enable_in_low,
	input wire logic config_restart_low,
	output logic chain_enable_out_low,
	// serial flash side
	input wire logic flash_data_in,
	input wire logic config_clock_in,
	output cfg_chain_pkg::flash_pins_t flash_out,
	output cfg_chain_pkg::flash_pins_t flash_oe,
	// shared open-drain lines
	input wire logic config_complete_in,
	output logic config_complete_out,
	output logic config_complete_oe,
	input wire logic status_in,
	output logic status_out,
	output logic status_oe,
	// received stream and state
	output logic data_bit_out,
	output logic data_bit_valid,
	output logic config_done,
	output logic config_error
);

	// wide enough for the command count as well as the image count
	localparam int CNT_W = $clog2(((RAW_BITS > cfg_chain_pkg::CMD_BITS) ? RAW_BITS
		: cfg_chain_pkg::CMD_BITS) + 1);
	localparam int NS = 10;

	if (RAW_BITS < 1 || PACKED_BITS < 1 || PACKED_BITS > RAW_BITS
		|| DONE_TIMEOUT < 1 || DONE_TIMEOUT >= (1 << cfg_chain_pkg::TMR_W)) begin : g_chk
		$error("image size or timeout out of range");
	end

	cfg_chain_pkg::cfg_state_t state_ff;
	logic [NS-1:0] s1_ff;
	logic [NS-1:0] s2_ff;
	logic [NS-1:0] pins;
	logic [1:0] role_sy;
	logic packed_sy, auto_sy, nce_sy, nrst_sy, fdata_sy, cclk_sy, cdone_sy, stat_sy;
	logic cclk_prev_ff;
	logic is_master_ff;
	logic packed_ff;
	logic [CNT_W-1:0] bit_cnt_ff;
	logic [CNT_W-1:0] img_last;
	logic [cfg_chain_pkg::TMR_W-1:0] tmr_ff;
	logic [31:0] cmd_sh_ff;
	logic [1:0] samp_ff;
	logic data_bit_ff, data_vld_ff, ceo_ff;
	logic gen_clk, gen_rise, gen_fall, run_clk, slave_rise, take_bit, last_bit;
	logic flash_busy;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	assign pins = {scheme_select, image_compressed, auto_restart, chain_enable_in_low,
		config_restart_low, flash_data_in, config_clock_in, config_complete_in, status_in};
	assign {role_sy, packed_sy, auto_sy, nce_sy, nrst_sy, fdata_sy, cclk_sy, cdone_sy,
		stat_sy} = s2_ff;

	// two-stage capture of every pin
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s1_ff <= '0;
			s2_ff <= '0;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
		end
	end

	// previous synced clock for slave edge detect
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cclk_prev_ff <= 1'b0;
		end else begin
			cclk_prev_ff <= cclk_sy;
		end
	end

	assign slave_rise = cclk_sy && !cclk_prev_ff; // R12

	// ----------------------------------------------------------------
	// configuration clock generator
	// ----------------------------------------------------------------
	assign run_clk = is_master_ff && !nce_sy
		&& (state_ff == cfg_chain_pkg::ST_CMD || state_ff == cfg_chain_pkg::ST_DATA);

	cfg_clock_gen #(
		.HALF_CYC(cfg_chain_pkg::CFG_HALF_CYC) // R6 R7
	) u_clk (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.run(run_clk),
		.clk_out(gen_clk),
		.rise(gen_rise),
		.fall(gen_fall)
	);

	// rise strobes in data phase, delayed to match the data synchroniser
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			samp_ff <= '0;
		end else begin
			samp_ff <= {samp_ff[0], gen_rise && state_ff == cfg_chain_pkg::ST_DATA};
		end
	end

	// ----------------------------------------------------------------
	// image length and bit taking
	// ----------------------------------------------------------------
	assign img_last = packed_ff ? CNT_W'(PACKED_BITS - 1) : CNT_W'(RAW_BITS - 1); // R8
	assign take_bit = (state_ff == cfg_chain_pkg::ST_DATA)
		&& (is_master_ff ? samp_ff[1] : slave_rise); // R5 R12
	assign last_bit = take_bit && bit_cnt_ff == img_last;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= cfg_chain_pkg::ST_HOLD;
		end else if (!nrst_sy) begin
			state_ff <= cfg_chain_pkg::ST_HOLD; // R10
		end else begin
			unique case (state_ff)
				cfg_chain_pkg::ST_HOLD: begin
					state_ff <= cfg_chain_pkg::ST_IDLE;
				end
				cfg_chain_pkg::ST_IDLE: begin
					if (!stat_sy) begin
						state_ff <= cfg_chain_pkg::ST_IDLE; // released status still settling
					end else if (role_sy == cfg_chain_pkg::SCHEME_SLAVE) begin
						state_ff <= cfg_chain_pkg::ST_DATA; // R1 R2
					end else if (role_sy != cfg_chain_pkg::SCHEME_MASTER) begin
						state_ff <= cfg_chain_pkg::ST_ERROR; // R1
					end else if (!nce_sy) begin
						state_ff <= cfg_chain_pkg::ST_CMD; // R9
					end
				end
				cfg_chain_pkg::ST_CMD: begin
					if (nce_sy) begin
						state_ff <= cfg_chain_pkg::ST_IDLE; // R9
					end else if (!stat_sy) begin
						state_ff <= cfg_chain_pkg::ST_ERROR;
					end else if (gen_rise && bit_cnt_ff == CNT_W'(cfg_chain_pkg::CMD_BITS - 1)) begin
						state_ff <= cfg_chain_pkg::ST_DATA;
					end
				end
				cfg_chain_pkg::ST_DATA: begin
					if (is_master_ff && nce_sy) begin
						state_ff <= cfg_chain_pkg::ST_IDLE; // R9
					end else if (!stat_sy) begin
						state_ff <= cfg_chain_pkg::ST_ERROR; // R14
					end else if (last_bit) begin
						state_ff <= cfg_chain_pkg::ST_WAIT;
					end
				end
				cfg_chain_pkg::ST_WAIT: begin
					if (cdone_sy) begin
						state_ff <= cfg_chain_pkg::ST_DONE; // R13
					end else if (!stat_sy || tmr_ff == cfg_chain_pkg::TMR_W'(DONE_TIMEOUT - 1)) begin
						state_ff <= cfg_chain_pkg::ST_ERROR;
					end
				end
				cfg_chain_pkg::ST_DONE: begin
					state_ff <= cfg_chain_pkg::ST_DONE;
				end
				cfg_chain_pkg::ST_ERROR: begin
					if (auto_sy && tmr_ff == cfg_chain_pkg::TMR_W'(cfg_chain_pkg::RESTART_CYC - 1)) begin
						state_ff <= cfg_chain_pkg::ST_IDLE; // R14
					end
				end
			endcase
		end
	end

	// straps caught when leaving idle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			is_master_ff <= 1'b0;
			packed_ff <= 1'b0;
		end else if (state_ff == cfg_chain_pkg::ST_IDLE) begin
			is_master_ff <= role_sy == cfg_chain_pkg::SCHEME_MASTER; // R1
			packed_ff <= packed_sy; // R8
		end
	end

	// bit counter: command bits, then image bits
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_ff <= '0;
		end else if (state_ff == cfg_chain_pkg::ST_CMD) begin
			if (gen_rise) begin
				bit_cnt_ff <= (bit_cnt_ff == CNT_W'(cfg_chain_pkg::CMD_BITS - 1)) ? '0
					: bit_cnt_ff + CNT_W'(1);
			end
		end else if (state_ff == cfg_chain_pkg::ST_DATA) begin
			if (take_bit) begin
				bit_cnt_ff <= bit_cnt_ff + CNT_W'(1); // R5
			end
		end else begin
			bit_cnt_ff <= '0;
		end
	end

	// wait and restart timer
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tmr_ff <= '0;
		end else if (state_ff == cfg_chain_pkg::ST_WAIT || state_ff == cfg_chain_pkg::ST_ERROR) begin
			tmr_ff <= tmr_ff + cfg_chain_pkg::TMR_W'(1);
		end else begin
			tmr_ff <= '0;
		end
	end

	// read command shifted on falling edges, flash samples on rising
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cmd_sh_ff <= '0;
		end else if (state_ff != cfg_chain_pkg::ST_CMD) begin
			cmd_sh_ff <= cfg_chain_pkg::FLASH_READ_WORD;
		end else if (gen_fall) begin
			cmd_sh_ff <= {cmd_sh_ff[30:0], 1'b0};
		end
	end

	// received stream to the fabric
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			data_bit_ff <= 1'b0;
			data_vld_ff <= 1'b0;
		end else begin
			data_vld_ff <= take_bit;
			if (take_bit) begin
				data_bit_ff <= fdata_sy; // R4 R12
			end
		end
	end

	// chain enable out goes low only when configured
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ceo_ff <= 1'b1;
		end else begin
			ceo_ff <= state_ff != cfg_chain_pkg::ST_DONE;
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	assign flash_busy = state_ff == cfg_chain_pkg::ST_CMD || state_ff == cfg_chain_pkg::ST_DATA;
	assign flash_out.config_clock = gen_clk; // R5 R6
	assign flash_out.flash_select_low = !flash_busy;
	assign flash_out.flash_command_out = cmd_sh_ff[31];
	assign flash_oe.config_clock = run_clk; // R9
	assign flash_oe.flash_select_low = is_master_ff && !nce_sy; // R9
	assign flash_oe.flash_command_out = run_clk; // R9
	assign config_complete_out = 1'b0;
	assign config_complete_oe = state_ff != cfg_chain_pkg::ST_WAIT
		&& state_ff != cfg_chain_pkg::ST_DONE; // R13
	assign status_out = 1'b0;
	assign status_oe = state_ff == cfg_chain_pkg::ST_HOLD
		|| state_ff == cfg_chain_pkg::ST_ERROR; // R10 R14
	assign chain_enable_out_low = ceo_ff;
	assign data_bit_out = data_bit_ff;
	assign data_bit_valid = data_vld_ff;
	assign config_done = state_ff == cfg_chain_pkg::ST_DONE;
	assign config_error = state_ff == cfg_chain_pkg::ST_ERROR;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_clk_high;
		$rose(gen_clk) ##1 !gen_clk;
	endsequence

	property p_clk_period;
		$rose(gen_clk) |-> s_clk_high ##1 (gen_clk || !run_clk);
	endproperty
	a_clk_period: assert property (p_clk_period) else $error("config clock too slow"); // R6

	property p_flash_off;
		nce_sy |-> flash_oe == '0;
	endproperty
	a_flash_off: assert property (p_flash_off) else $error("flash driven while disabled"); // R9

	property p_hold;
		!nrst_sy |=> state_ff == cfg_chain_pkg::ST_HOLD && status_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("not held in reset"); // R10

	property p_done_low;
		state_ff == cfg_chain_pkg::ST_DATA |-> config_complete_oe && !config_done;
	endproperty
	a_done_low: assert property (p_done_low) else $error("done released early"); // R13

	property p_last;
		last_bit && stat_sy && nrst_sy && !(is_master_ff && nce_sy)
			|=> state_ff == cfg_chain_pkg::ST_WAIT ##0 !config_complete_oe;
	endproperty
	a_last: assert property (p_last) else $error("image end not honoured"); // R2 R13

	property p_restart;
		state_ff == cfg_chain_pkg::ST_ERROR && auto_sy && nrst_sy
			&& tmr_ff == cfg_chain_pkg::TMR_W'(cfg_chain_pkg::RESTART_CYC - 1)
			|=> state_ff == cfg_chain_pkg::ST_IDLE;
	endproperty
	a_restart: assert property (p_restart) else $error("no auto restart"); // R14

	property p_slave_latch;
		take_bit && !is_master_ff |=> data_bit_valid && data_bit_out == $past(fdata_sy);
	endproperty
	a_slave_latch: assert property (p_slave_latch) else $error("slave bit lost"); // R12

	property p_count;
		take_bit && state_ff == cfg_chain_pkg::ST_DATA && !last_bit && nrst_sy && stat_sy
			&& !(is_master_ff && nce_sy) |=> bit_cnt_ff == $past(bit_cnt_ff) + CNT_W'(1);
	endproperty
	a_count: assert property (p_count) else $error("bit count slipped"); // R5

	property p_size;
		state_ff == cfg_chain_pkg::ST_DATA && packed_ff
			|-> img_last == CNT_W'(PACKED_BITS - 1);
	endproperty
	a_size: assert property (p_size) else $error("wrong image length"); // R8

	property p_bad_strap;
		state_ff == cfg_chain_pkg::ST_IDLE && nrst_sy && stat_sy && role_sy[1]
			|=> state_ff == cfg_chain_pkg::ST_ERROR ##1 status_oe;
	endproperty
	a_bad_strap: assert property (p_bad_strap) else $error("bad strap accepted"); // R1

endmodule

// [hdl/cfg_chain_pkg.sv]
// constants and types for the serial chain configuration loader
package cfg_chain_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int T_CLK_NS = 20;
	localparam int CFG_CLK_MAX_PERIOD_NS = 50;
	localparam int CFG_CLK_TYP_PERIOD_PS = 38460;
	// longest period rounds down to whole half periods of the system clock
	localparam int CFG_HALF_CYC_RAW = CFG_CLK_MAX_PERIOD_NS / 2 / T_CLK_NS;
	localparam int CFG_HALF_CYC = (CFG_HALF_CYC_RAW < 1) ? 1 : CFG_HALF_CYC_RAW;
	localparam int RESTART_TIMEOUT_NS = 40000;
	localparam int RESTART_CYC = RESTART_TIMEOUT_NS / T_CLK_NS;
	localparam int TMR_W = 24;

	// ----------------------------------------------------------------
	// straps, flash command, image sizes
	// ----------------------------------------------------------------
	localparam logic [1:0] SCHEME_MASTER = 2'h0;
	localparam logic [1:0] SCHEME_SLAVE = 2'h1;
	localparam logic [31:0] FLASH_READ_WORD = 32'h03000000;
	localparam int CMD_BITS = 32;
	localparam int RAW_IMAGE_BITS = 1223980;
	localparam int PACKED_IMAGE_BITS = 611990;
	localparam int DONE_TIMEOUT_CYC = 100000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum {ST_IDLE, ST_HOLD, ST_CMD, ST_DATA, ST_WAIT, ST_DONE, ST_ERROR} cfg_state_t;

	typedef struct packed {
		logic config_clock;
		logic flash_select_low;
		logic flash_command_out;
	} flash_pins_t;

endpackage

// [hdl/cfg_clock_gen.sv]
// configuration clock divider with edge strobes
`timescale 1ns/1ns
module cfg_clock_gen #(
	parameter int HALF_CYC = cfg_chain_pkg::CFG_HALF_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// control
	input wire logic run,
	// clock and strobes
	output logic clk_out,
	output logic rise,
	output logic fall
);

	localparam int HW = (HALF_CYC < 2) ? 1 : $clog2(HALF_CYC);

	logic clk_ff;
	logic [HW-1:0] cnt_ff;
	logic tick;

	if (HALF_CYC < 1) begin : g_chk
		$error("half period must be at least one cycle");
	end

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	assign tick = run && (cnt_ff == HW'(HALF_CYC - 1));
	assign rise = tick && !clk_ff;
	assign fall = tick && clk_ff;
	assign clk_out = clk_ff;

	// half period counter, parked low when stopped
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= '0;
			clk_ff <= 1'b0;
		end else if (!run) begin
			cnt_ff <= '0;
			clk_ff <= 1'b0;
		end else if (tick) begin
			cnt_ff <= '0;
			clk_ff <= !clk_ff;
		end else begin
			cnt_ff <= cnt_ff + HW'(1);
		end
	end

endmodule

// [verification/cfg_flash_model.sv]
// behavioural serial flash holding one shared image
`timescale 1ns/1ns
module cfg_flash_model (
	// pins from the master
	input wire logic config_clock,
	input wire logic flash_select_low,
	input wire logic flash_command_out,
	// data back to the chain and what was asked
	output logic flash_data,
	output logic [31:0] cmd_seen
);
	int cmd_cnt;
	int bits;
	logic clk_q;

	// image content, same pattern the bench expects
	function automatic logic img_bit(input int n);
		return n[0] ^ n[1] ^ n[3];
	endfunction

	initial begin
		cmd_cnt = 0;
		bits = 0;
		clk_q = 1'b0;
		flash_data = 1'b0;
		cmd_seen = 32'h0;
	end

	// command in on rising clock, image out on falling clock
	always @(config_clock or flash_select_low) begin
		if (flash_select_low) begin
			cmd_cnt = 0;
			bits = 0;
			flash_data <= ~flash_data; // released line does not hold its value
		end else if (config_clock && !clk_q && cmd_cnt < 32) begin
			cmd_seen <= {cmd_seen[30:0], flash_command_out};
			cmd_cnt = cmd_cnt + 1;
		end else if (!config_clock && clk_q && cmd_cnt == 32) begin
			flash_data <= img_bit(bits);
			bits = bits + 1;
		end
		clk_q = config_clock;
	end
endmodule

// [verification/serial_chain_config_broadcast_tb.sv]
// self-checking bench for the chain configuration loader
`timescale 1ns/1ns
module serial_chain_config_broadcast_tb;
	localparam int P_RAW = 40;
	localparam int P_PACKED = 20;
	localparam int LIMIT = 20000;
	logic clk_sys, rstn;
	logic [1:0] scheme_select;
	logic image_compressed, auto_restart, chain_enable_in_low, config_restart_low;
	logic slave_mode, sclk, sdat, hold_done, status_force, fdat, pin_q;
	logic chain_enable_out_low, config_complete_out, config_complete_oe, status_out, status_oe;
	logic data_bit_out, data_bit_valid, config_done, config_error;
	logic clk_pin, sel_pin, cmd_pin, config_complete_in, status_in;
	logic [31:0] cmd_seen;
	cfg_chain_pkg::flash_pins_t flash_out, flash_oe;
	int bad_count, comparisons, rx_n, cycles, last_rise;

	// ----------------------------------------------------------------
	// pins, pull-ups and far side
	// ----------------------------------------------------------------
	assign clk_pin = flash_oe.config_clock ? flash_out.config_clock : 1'b0;
	assign sel_pin = flash_oe.flash_select_low ? flash_out.flash_select_low : 1'b1;
	assign cmd_pin = flash_oe.flash_command_out ? flash_out.flash_command_out : 1'b1;
	assign config_complete_in = ~(config_complete_oe & ~config_complete_out) & ~hold_done;
	assign status_in = ~(status_oe & ~status_out) & ~status_force;

	cfg_chain_loader #(.RAW_BITS(P_RAW), .PACKED_BITS(P_PACKED), .DONE_TIMEOUT(200)) DUT (
		.clk_sys(clk_sys), .rstn(rstn), .scheme_select(scheme_select),
		.image_compressed(image_compressed), .auto_restart(auto_restart),
		.chain_enable_in_low(chain_enable_in_low), .config_restart_low(config_restart_low),
		.chain_enable_out_low(chain_enable_out_low),
		.flash_data_in(slave_mode ? sdat : fdat), .config_clock_in(slave_mode ? sclk : clk_pin),
		.flash_out(flash_out), .flash_oe(flash_oe),
		.config_complete_in(config_complete_in), .config_complete_out(config_complete_out),
		.config_complete_oe(config_complete_oe), .status_in(status_in),
		.status_out(status_out), .status_oe(status_oe), .data_bit_out(data_bit_out),
		.data_bit_valid(data_bit_valid), .config_done(config_done), .config_error(config_error)
	);

	cfg_flash_model flash (
		.config_clock(clk_pin), .flash_select_low(sel_pin), .flash_command_out(cmd_pin),
		.flash_data(fdat), .cmd_seen(cmd_seen)
	);

	// ----------------------------------------------------------------
	// clock, timeout, stream and clock period watchers
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	function automatic logic img(input int n);
		return n[0] ^ n[1] ^ n[3];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// cycle ceiling, counted as a mismatch
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			bad_count++;
			give_verdict();
		end
	end

	// every received bit must match the shared image
	always @(posedge clk_sys) begin
		if (data_bit_valid === 1'b1) begin
			check(data_bit_out, img(rx_n));
			rx_n++;
		end
		pin_q <= clk_pin;
		if (sel_pin) begin
			last_rise <= 0;
		end else if (clk_pin && !pin_q) begin
			if (last_rise != 0) begin
				check(cycles - last_rise, 2 * cfg_chain_pkg::CFG_HALF_CYC);
			end
			last_rise <= cycles;
		end
	end

	// ----------------------------------------------------------------
	// shared steps
	// ----------------------------------------------------------------
	task automatic restart();
		@(posedge clk_sys);
		config_restart_low <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		check(status_oe, 1'b1);
		check(config_done | config_error, 1'b0);
		rx_n = 0;
		@(posedge clk_sys);
		config_restart_low <= 1'b1;
	endtask

	task automatic set_straps(input logic [1:0] sch, input logic comp, input logic slv);
		@(posedge clk_sys);
		scheme_select <= sch;
		image_compressed <= comp;
		slave_mode <= slv;
		hold_done <= 1'b1;
		restart();
	endtask

	task automatic wait_bits(input int n);
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (rx_n < n && k < 1000);
	endtask

	task automatic wait_loaded(input int bits);
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (config_complete_oe !== 1'b0 && k < 4000);
		@(posedge clk_sys);
		#1;
		check(rx_n, bits);
	endtask

	// another device still loading keeps the shared line low
	task automatic finish_done();
		repeat (5) @(posedge clk_sys);
		#1;
		check(config_done, 1'b0);
		@(posedge clk_sys);
		hold_done <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		check(config_done, 1'b1);
		check(chain_enable_out_low, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic master_load(input logic comp);
		set_straps(cfg_chain_pkg::SCHEME_MASTER, comp, 1'b0);
		wait_loaded(comp ? P_PACKED : P_RAW);
		check(cmd_seen, cfg_chain_pkg::FLASH_READ_WORD);
		finish_done();
	endtask

	// programmer takes the flash mid-load, then hands it back
	task automatic abort_load();
		int k;
		set_straps(cfg_chain_pkg::SCHEME_MASTER, 1'b1, 1'b0);
		wait_bits(5);
		@(posedge clk_sys);
		chain_enable_in_low <= 1'b1;
		repeat (5) @(posedge clk_sys);
		#1;
		check(32'(flash_oe), 32'h0);
		k = rx_n;
		repeat (40) @(posedge clk_sys);
		#1;
		check(rx_n, k);
		rx_n = 0;
		@(posedge clk_sys);
		chain_enable_in_low <= 1'b0;
		wait_loaded(P_PACKED);
		check(cmd_seen, cfg_chain_pkg::FLASH_READ_WORD);
		finish_done();
	endtask

	// data flips while the clock is high: only the rising edge value counts
	task automatic slave_load();
		int i;
		set_straps(cfg_chain_pkg::SCHEME_SLAVE, 1'b1, 1'b1);
		repeat (4) @(posedge clk_sys);
		for (i = 0; i < P_PACKED; i++) begin
			sclk <= 1'b0;
			sdat <= img(i);
			repeat (3) @(posedge clk_sys);
			sclk <= 1'b1;
			repeat (3) @(posedge clk_sys);
			sdat <= ~img(i);
			@(posedge clk_sys);
		end
		#1;
		check(32'(flash_oe), 32'h0);
		wait_loaded(P_PACKED);
		finish_done();
	endtask

	task automatic error_restart();
		int k;
		@(posedge clk_sys);
		auto_restart <= 1'b1;
		set_straps(cfg_chain_pkg::SCHEME_MASTER, 1'b1, 1'b0);
		wait_bits(3);
		@(posedge clk_sys);
		status_force <= 1'b1;
		repeat (5) @(posedge clk_sys);
		status_force <= 1'b0;
		#1;
		check(config_error, 1'b1);
		check(status_oe, 1'b1);
		rx_n = 0;
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (config_error === 1'b1 && k < 2100);
		check(k <= cfg_chain_pkg::RESTART_CYC && k >= cfg_chain_pkg::RESTART_CYC - 10, 1);
		wait_loaded(P_PACKED);
		finish_done();
		@(posedge clk_sys);
		auto_restart <= 1'b0;
		set_straps(2'h2, 1'b1, 1'b0);
		repeat (100) @(posedge clk_sys);
		#1;
		check(config_error, 1'b1);
		check(32'(flash_oe), 32'h0);
	endtask

	initial begin
		rstn = 1'b0;
		scheme_select = 2'h0;
		image_compressed = 1'b1;
		auto_restart = 1'b0;
		chain_enable_in_low = 1'b0;
		config_restart_low = 1'b1;
		slave_mode = 1'b0;
		sclk = 1'b0;
		sdat = 1'b0;
		hold_done = 1'b0;
		status_force = 1'b0;
		pin_q = 1'b0;
		bad_count = 0;
		comparisons = 0;
		rx_n = 0;
		cycles = 0;
		last_rise = 0;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		master_load(1'b1);
		master_load(1'b0);
		abort_load();
		slave_load();
		error_restart();
		give_verdict();
	end
endmodule
